// File: rtl/tpc_timer.sv
// tpc_timer: 16-bit timer with input capture, shared shadow byte and dual phase-correct pwm
// assumes a byte register port, strobes one cycle, pins synchronous to ref_clk
// Behaviour
// - selected capture edge copies counter, sets flag
// - capture value sixteen bits, read-only, reset zero
// - low read returns byte, parks high byte
// - pwm counts up to top, down
// - top 255, 511 or 1023 by resolution
// - pwm match on ten low compare bits, all sixteen otherwise
// - mode 10 non-inverted, 11 inverted, else off
// - pwm compare writes latched at top
// - pending compare reads return holding value
// - zero or undivided top compare gives constant output
// - top compare undivided gives no pulse
// - top compare divided gives full-period pulse
// - overflow flag set leaving zero in pwm, wrapping past all ones otherwise
// - flags request interrupt with both enables
// - edge select zero falling, one rising
// - three-bit clock select chooses source
// - clear-on-match ignored in pwm mode
`timescale 1ns/1ns
`default_nettype none
module tpc_timer
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic [7:0]      reg_rdata,
   input  wire logic       capture_input_pin,
   input  wire logic       ext_clk_pin,
   output logic            compare_a_output,
   output logic            compare_a_output_en,
   output logic            compare_b_output,
   output logic            compare_b_output_en,
   output logic            irq
);
   logic [7:0]  timer_control_a_reg;
   logic [7:0]  timer_control_b_reg;
   logic [15:0] counter_value_reg;
   logic [15:0] counter_value_next;
   logic [15:0] compare_a_value_reg;
   logic [15:0] compare_b_value_reg;
   logic [15:0] hold_a_reg;
   logic [15:0] hold_b_reg;
   logic [15:0] capture_value_reg;
   logic [7:0]  shadow_reg;
   logic [7:0]  rdata_reg;
   logic [3:0]  flags_reg;
   logic [7:0]  irq_en_reg;
   logic        cap_pin_reg;
   logic        out_a_reg;
   logic        out_b_reg;
   logic        match_a_reg;
   logic        match_b_reg;
   logic        a_top_armed_reg;
   logic        b_top_armed_reg;
   tpc_pkg::tpc_dir_type dir_reg;
   tpc_pkg::tpc_dir_type dir_next;

   logic        tick;
   logic [1:0]  pwm_sel;
   logic        pwm_on;
   logic [15:0] top;
   logic [2:0]  prescale;
   logic        undivided;
   logic        cap_edge;
   logic        at_top;
   logic        at_zero;
   logic        going_up;
   logic        match_a_now;
   logic        match_b_now;
   logic        ovf_event;
   logic        wr_cnt_low;
   logic        wr_cmpa_low;
   logic        wr_cmpb_low;
   logic        wr_high;
   logic        rd_low16;
   logic [15:0] rd_word;
   logic [7:0]  rd_byte;
   logic [1:0]  mode_a;
   logic [1:0]  mode_b;
   logic [3:0]  flag_set;
   logic [3:0]  flag_clr;
   logic        up_a_now;
   logic        up_b_now;
   logic        top_a;
   logic        top_b;

   // pwm top for the selected resolution
   function automatic logic [15:0] top_of(input logic [1:0] sel);
      case (sel)
         tpc_pkg::TPC_PWM_8:  top_of = tpc_pkg::TOP_8BIT;
         tpc_pkg::TPC_PWM_9:  top_of = tpc_pkg::TOP_9BIT;
         default:             top_of = tpc_pkg::TOP_10BIT;
      endcase
   endfunction : top_of

   // next pin level on a match; mode 10 clears going up, 11 sets going up
   function automatic logic pin_on_match(input logic [1:0] mode, input logic up);
      pin_on_match = mode[0] ? up : ~up;
   endfunction : pin_on_match

   tpc_prescaler u_prescaler
   (
      .ref_clk               (ref_clk),
      .rst                   (rst),
      .clock_prescale_select (prescale),
      .ext_clk_pin           (ext_clk_pin),
      .tick                  (tick)
   );

   assign pwm_sel   = timer_control_a_reg[tpc_pkg::PWM_SEL_POS +: 2];
   assign pwm_on    = (pwm_sel != tpc_pkg::TPC_PWM_OFF);
   assign top       = top_of(pwm_sel);
   assign mode_a    = timer_control_a_reg[tpc_pkg::OUT_A_MODE_POS +: 2];
   assign mode_b    = timer_control_a_reg[tpc_pkg::OUT_B_MODE_POS +: 2];
   assign prescale  = timer_control_b_reg[tpc_pkg::PRESCALE_POS +: 3];
   assign undivided = (prescale == tpc_pkg::TPC_CS_DIV1);
   assign at_top    = (counter_value_reg == top);
   assign at_zero   = (counter_value_reg == 16'h0000);
   assign going_up  = (dir_reg == tpc_pkg::TPC_DIR_UP);

   // edge select picks which transition of the pin captures
   assign cap_edge = timer_control_b_reg[tpc_pkg::EDGE_SEL_POS] ?
                     (capture_input_pin & ~cap_pin_reg) :
                     (~capture_input_pin & cap_pin_reg);

   // matches only when the counter steps onto the value, never on a software preset
   assign match_a_now = tick & (counter_value_next == compare_a_value_reg) &
                        (counter_value_next != counter_value_reg);
   assign match_b_now = tick & (counter_value_next == compare_b_value_reg) &
                        (counter_value_next != counter_value_reg);

   // a zero compare is only met at the bottom turn, which acts as an up match
   assign up_a_now = (dir_next == tpc_pkg::TPC_DIR_UP) | (compare_a_value_reg == 16'h0000);
   assign up_b_now = (dir_next == tpc_pkg::TPC_DIR_UP) | (compare_b_value_reg == 16'h0000);
   assign top_a    = (compare_a_value_reg == top);
   assign top_b    = (compare_b_value_reg == top);

   // overflow: leaving zero in pwm, wrapping past all ones otherwise
   assign ovf_event = tick & (pwm_on ? at_zero : (counter_value_reg == 16'hFFFF));

   // counter and direction
   always_comb
   begin
      counter_value_next = counter_value_reg;
      dir_next           = dir_reg;
      if (tick)
      begin
         if (pwm_on)
         begin
            // clear-on-match has no say here
            if (at_top)
            begin
               counter_value_next = counter_value_reg - 16'h0001;
               dir_next           = tpc_pkg::TPC_DIR_DOWN;
            end
            else if (at_zero)
            begin
               counter_value_next = 16'h0001;
               dir_next           = tpc_pkg::TPC_DIR_UP;
            end
            else if (going_up)
               counter_value_next = counter_value_reg + 16'h0001;
            else
               counter_value_next = counter_value_reg - 16'h0001;
         end
         else if (timer_control_b_reg[tpc_pkg::CLR_MATCH_POS] && match_a_reg)
            counter_value_next = 16'h0000;
         else
            counter_value_next = counter_value_reg + 16'h0001;
      end
   end

   // register access decode
   assign wr_cnt_low  = reg_write & (reg_addr == tpc_pkg::ADDR_CNT_LOW);
   assign wr_cmpa_low = reg_write & (reg_addr == tpc_pkg::ADDR_CMPA_LOW);
   assign wr_cmpb_low = reg_write & (reg_addr == tpc_pkg::ADDR_CMPB_LOW);
   assign wr_high     = reg_write & ((reg_addr == tpc_pkg::ADDR_CNT_HIGH) |
                        (reg_addr == tpc_pkg::ADDR_CMPA_HIGH) | (reg_addr == tpc_pkg::ADDR_CMPB_HIGH));
   assign rd_low16    = reg_read & ((reg_addr == tpc_pkg::ADDR_CNT_LOW) |
                        (reg_addr == tpc_pkg::ADDR_CMPA_LOW) | (reg_addr == tpc_pkg::ADDR_CMPB_LOW) |
                        (reg_addr == tpc_pkg::ADDR_CAP_LOW));

   // compare reads show the holding word, so the last write reads back
   assign rd_word = (reg_addr == tpc_pkg::ADDR_CNT_LOW)  ? counter_value_reg :
                    (reg_addr == tpc_pkg::ADDR_CMPA_LOW) ? hold_a_reg :
                    (reg_addr == tpc_pkg::ADDR_CMPB_LOW) ? hold_b_reg :
                    capture_value_reg;

   always_comb
   begin
      case (reg_addr)
         tpc_pkg::ADDR_CTRL_A:    rd_byte = timer_control_a_reg;
         tpc_pkg::ADDR_CTRL_B:    rd_byte = timer_control_b_reg & 8'h4F;
         tpc_pkg::ADDR_CNT_LOW,
         tpc_pkg::ADDR_CMPA_LOW,
         tpc_pkg::ADDR_CMPB_LOW,
         tpc_pkg::ADDR_CAP_LOW:   rd_byte = rd_word[7:0];
         tpc_pkg::ADDR_CNT_HIGH,
         tpc_pkg::ADDR_CMPA_HIGH,
         tpc_pkg::ADDR_CMPB_HIGH,
         tpc_pkg::ADDR_CAP_HIGH:  rd_byte = shadow_reg;
         tpc_pkg::ADDR_FLAGS:     rd_byte = {4'h0, flags_reg};
         tpc_pkg::ADDR_IRQ_EN:    rd_byte = irq_en_reg & 8'h8F;
         default:                 rd_byte = 8'h00;
      endcase
   end

   // flags: write one to clear, a same-cycle event wins
   assign flag_set = {cap_edge, match_b_now, match_a_now, ovf_event};
   assign flag_clr = (reg_write && reg_addr == tpc_pkg::ADDR_FLAGS) ? reg_wdata[3:0] : 4'h0;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         timer_control_a_reg <= tpc_pkg::CTRL_RESET;
         timer_control_b_reg <= tpc_pkg::CTRL_RESET;
         irq_en_reg          <= tpc_pkg::CTRL_RESET;
         shadow_reg          <= tpc_pkg::CTRL_RESET;
         rdata_reg           <= tpc_pkg::CTRL_RESET;
         flags_reg           <= 4'h0;
      end
      else
      begin
         if (reg_write && reg_addr == tpc_pkg::ADDR_CTRL_A)
            timer_control_a_reg <= reg_wdata;
         if (reg_write && reg_addr == tpc_pkg::ADDR_CTRL_B)
            timer_control_b_reg <= reg_wdata;
         if (reg_write && reg_addr == tpc_pkg::ADDR_IRQ_EN)
            irq_en_reg <= reg_wdata;
         if (rd_low16)
            shadow_reg <= rd_word[15:8];
         else if (wr_high)
            shadow_reg <= reg_wdata;
         if (reg_read)
            rdata_reg <= rd_byte;
         flags_reg <= (flags_reg & ~flag_clr) | flag_set;
      end
   end

   // counter, capture and compare words
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         counter_value_reg   <= tpc_pkg::WORD_RESET;
         capture_value_reg   <= tpc_pkg::WORD_RESET;
         compare_a_value_reg <= tpc_pkg::WORD_RESET;
         compare_b_value_reg <= tpc_pkg::WORD_RESET;
         hold_a_reg          <= tpc_pkg::WORD_RESET;
         hold_b_reg          <= tpc_pkg::WORD_RESET;
         dir_reg             <= tpc_pkg::TPC_DIR_UP;
         cap_pin_reg         <= 1'b0;
      end
      else
      begin
         cap_pin_reg <= capture_input_pin;
         dir_reg     <= dir_next;
         if (wr_cnt_low)
            counter_value_reg <= {shadow_reg, reg_wdata};
         else
            counter_value_reg <= counter_value_next;
         if (cap_edge)
            capture_value_reg <= counter_value_reg;
         if (wr_cmpa_low)
            hold_a_reg <= {shadow_reg, reg_wdata};
         if (wr_cmpb_low)
            hold_b_reg <= {shadow_reg, reg_wdata};
         // pwm compares only take the held ten bits at top, avoiding odd pulses
         if (!pwm_on || (tick && at_top))
         begin
            compare_a_value_reg <= pwm_on ? {6'h00, hold_a_reg[9:0]} : hold_a_reg;
            compare_b_value_reg <= pwm_on ? {6'h00, hold_b_reg[9:0]} : hold_b_reg;
         end
      end
   end

   // output pins; top compare with a divider arms the up match until top recurs
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         out_a_reg       <= 1'b0;
         out_b_reg       <= 1'b0;
         match_a_reg     <= 1'b0;
         match_b_reg     <= 1'b0;
         a_top_armed_reg <= 1'b0;
         b_top_armed_reg <= 1'b0;
      end
      else
      begin
         // a divided tick comes later, so the a match waits for it; the b match is kept one cycle only
         match_a_reg <= match_a_now | (match_a_reg & ~tick);
         match_b_reg <= match_b_now;
         if (pwm_on && mode_a[1] && match_a_now)
         begin
            if (top_a)
            begin
               // undivided: up and down matches coincide, output goes inactive
               if (undivided || a_top_armed_reg)
                  out_a_reg <= pin_on_match(mode_a, 1'b1);
               else
                  out_a_reg <= pin_on_match(mode_a, 1'b0);
               a_top_armed_reg <= ~undivided & ~a_top_armed_reg;
            end
            else
               out_a_reg <= pin_on_match(mode_a, up_a_now);
         end
         if (pwm_on && mode_b[1] && match_b_now)
         begin
            if (top_b)
            begin
               if (undivided || b_top_armed_reg)
                  out_b_reg <= pin_on_match(mode_b, 1'b1);
               else
                  out_b_reg <= pin_on_match(mode_b, 1'b0);
               b_top_armed_reg <= ~undivided & ~b_top_armed_reg;
            end
            else
               out_b_reg <= pin_on_match(mode_b, up_b_now);
         end
      end
   end

   assign compare_a_output    = out_a_reg;
   assign compare_b_output    = out_b_reg;
   assign compare_a_output_en = pwm_on & mode_a[1];
   assign compare_b_output_en = pwm_on & mode_b[1];
   assign reg_rdata           = rdata_reg;
   // request line for the core; global enable and per-flag enables
   assign irq = irq_en_reg[tpc_pkg::GLOBAL_EN_POS] & |(flags_reg & irq_en_reg[3:0]);
endmodule : tpc_timer
`default_nettype wire

// File: rtl/tpc_pkg.sv
// tpc_pkg: shared constants for the 16-bit timer with capture and phase-correct pwm
// assumes a byte-wide register port, one 100 MHz clock
`default_nettype none
package tpc_pkg;
   // byte register offsets on the plain register port
   localparam logic [3:0] ADDR_CTRL_A    = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B    = 4'h1;
   localparam logic [3:0] ADDR_CNT_LOW   = 4'h2;
   localparam logic [3:0] ADDR_CNT_HIGH  = 4'h3;
   localparam logic [3:0] ADDR_CMPA_LOW  = 4'h4;
   localparam logic [3:0] ADDR_CMPA_HIGH = 4'h5;
   localparam logic [3:0] ADDR_CMPB_LOW  = 4'h6;
   localparam logic [3:0] ADDR_CMPB_HIGH = 4'h7;
   localparam logic [3:0] ADDR_CAP_LOW   = 4'h8;
   localparam logic [3:0] ADDR_CAP_HIGH  = 4'h9;
   localparam logic [3:0] ADDR_FLAGS     = 4'hA;
   localparam logic [3:0] ADDR_IRQ_EN    = 4'hB;
   // control a fields
   localparam int OUT_A_MODE_POS  = 6;
   localparam int OUT_B_MODE_POS  = 4;
   localparam int PWM_SEL_POS     = 0;
   // control b fields
   localparam int EDGE_SEL_POS    = 6;
   localparam int CLR_MATCH_POS   = 3;
   localparam int PRESCALE_POS    = 0;
   // flag and enable bit positions
   localparam int FLAG_OVF_POS    = 0;
   localparam int FLAG_CMPA_POS   = 1;
   localparam int FLAG_CMPB_POS   = 2;
   localparam int FLAG_CAP_POS    = 3;
   localparam int GLOBAL_EN_POS   = 7;
   // reset values
   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [15:0] WORD_RESET  = 16'h0000;
   // pwm top values
   localparam logic [15:0] TOP_8BIT   = 16'h00FF;
   localparam logic [15:0] TOP_9BIT   = 16'h01FF;
   localparam logic [15:0] TOP_10BIT  = 16'h03FF;
   // prescale divisors, terminal counts of the divider
   localparam logic [9:0] DIV8_LAST    = 10'h007;
   localparam logic [9:0] DIV64_LAST   = 10'h03F;
   localparam logic [9:0] DIV256_LAST  = 10'h0FF;
   localparam logic [9:0] DIV1024_LAST = 10'h3FF;
   typedef enum logic [2:0]
   {
      TPC_CS_STOP = 3'h0, TPC_CS_DIV1 = 3'h1, TPC_CS_DIV8 = 3'h2, TPC_CS_DIV64 = 3'h3,
      TPC_CS_DIV256 = 3'h4, TPC_CS_DIV1024 = 3'h5, TPC_CS_EXT_FALL = 3'h6, TPC_CS_EXT_RISE = 3'h7
   } tpc_prescale_type;
   typedef enum logic [1:0]
   {
      TPC_PWM_OFF = 2'h0, TPC_PWM_8 = 2'h1, TPC_PWM_9 = 2'h2, TPC_PWM_10 = 2'h3
   } tpc_pwm_type;
   // one-hot count direction
   typedef enum logic [1:0]
   {
      TPC_DIR_UP = 2'b01, TPC_DIR_DOWN = 2'b10
   } tpc_dir_type;
endpackage : tpc_pkg
`default_nettype wire

// File: rtl/tpc_prescaler.sv
// tpc_prescaler: makes the one-cycle counter tick from the selected clock source
// assumes ext_clk_pin is synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
module tpc_prescaler
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [2:0] clock_prescale_select,
   input  wire logic       ext_clk_pin,
   output logic            tick
);
   logic [9:0] div_reg;
   logic       ext_reg;
   logic [9:0] last;
   logic       wrap;
   logic       ext_rise;
   logic       ext_fall;

   // free-running divider shared by all divided rates
   assign last = (clock_prescale_select == tpc_pkg::TPC_CS_DIV8)   ? tpc_pkg::DIV8_LAST :
                 (clock_prescale_select == tpc_pkg::TPC_CS_DIV64)  ? tpc_pkg::DIV64_LAST :
                 (clock_prescale_select == tpc_pkg::TPC_CS_DIV256) ? tpc_pkg::DIV256_LAST :
                 tpc_pkg::DIV1024_LAST;
   assign wrap     = ((div_reg & last) == last);
   assign ext_rise = ext_clk_pin & ~ext_reg;
   assign ext_fall = ~ext_clk_pin & ext_reg;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         div_reg <= 10'h000;
         ext_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_reg + 10'h001;
         ext_reg <= ext_clk_pin;
      end
   end

   always_comb
   begin
      case (clock_prescale_select)
         tpc_pkg::TPC_CS_STOP:     tick = 1'b0;
         tpc_pkg::TPC_CS_DIV1:     tick = 1'b1;
         tpc_pkg::TPC_CS_EXT_FALL: tick = ext_fall;
         tpc_pkg::TPC_CS_EXT_RISE: tick = ext_rise;
         default:                  tick = wrap;
      endcase
   end
endmodule : tpc_prescaler
`default_nettype wire

// File: testbench/tpc_timer_asserts.sv
// tpc_timer_asserts: port-level checks of the timer, bound to every tpc_timer
// assumes register strobes one cycle long and never together
`timescale 1ns/1ns
`default_nettype none
module tpc_timer_chk
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       capture_input_pin,
   input wire logic       ext_clk_pin,
   input wire logic       compare_a_output,
   input wire logic       compare_a_output_en,
   input wire logic       compare_b_output,
   input wire logic       compare_b_output_en,
   input wire logic       irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // what software last wrote, seen from the bus alone
   logic [7:0]      mir_reg [0:15];
   wire logic [7:0] ca = mir_reg[tpc_pkg::ADDR_CTRL_A];
   wire logic [7:0] cb = mir_reg[tpc_pkg::ADDR_CTRL_B];
   wire logic [7:0] ie = mir_reg[tpc_pkg::ADDR_IRQ_EN];
   wire logic       rd_a = reg_read && reg_addr == tpc_pkg::ADDR_CTRL_A;
   wire logic       rd_b = reg_read && reg_addr == tpc_pkg::ADDR_CTRL_B;
   wire logic       rd_e = reg_read && reg_addr == tpc_pkg::ADDR_IRQ_EN;
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         mir_reg <= '{default: 8'h00};
      else if (reg_write)
         mir_reg[reg_addr] <= reg_wdata;
   property p_en_a; compare_a_output_en == (ca[7] && ca[1:0] != 2'h0); endproperty
   a_en_a: assert property (p_en_a) else $error("pin a enable wrong");
   property p_en_b; compare_b_output_en == (ca[5] && ca[1:0] != 2'h0); endproperty
   a_en_b: assert property (p_en_b) else $error("pin b enable wrong");
   property p_irq; irq |-> ie[7] && (ie[3:0] != 4'h0); endproperty
   a_irq: assert property (p_irq) else $error("interrupt without enables");
   property p_hold; !reg_read |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   property p_rb_a; rd_a |=> reg_rdata[7:4] == ca[7:4] && reg_rdata[1:0] == ca[1:0]; endproperty
   a_rb_a: assert property (p_rb_a) else $error("control a readback wrong");
   property p_rb_b; rd_b |=> reg_rdata[6:0] == {cb[6], 2'h0, cb[3:0]}; endproperty
   a_rb_b: assert property (p_rb_b) else $error("control b readback wrong");
   property p_rb_e; rd_e |=> {reg_rdata[7], reg_rdata[3:0]} == {ie[7], ie[3:0]}; endproperty
   a_rb_e: assert property (p_rb_e) else $error("enable readback wrong");
   property p_unmap; reg_read && reg_addr >= 4'hC |=> reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   c_irq: cover property ($rose(irq));
   c_pwm: cover property ($rose(compare_a_output));
   c_cap: cover property (reg_read && reg_addr == tpc_pkg::ADDR_CAP_LOW);
endmodule : tpc_timer_chk
bind tpc_timer tpc_timer_chk u_chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
   .reg_rdata, .capture_input_pin, .ext_clk_pin, .compare_a_output, .compare_a_output_en,
   .compare_b_output, .compare_b_output_en, .irq);
`default_nettype wire

// File: testbench/tpc_cpu_model.sv
// tpc_cpu_model: processor side of the timer register port, one access at a time
// assumes strobes sampled on rising ref_clk, read data valid one cycle later
`timescale 1ns/1ns
`default_nettype none
module tpc_cpu_model
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output logic [3:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_write,
   output logic            reg_read
);
   initial
   begin
      reg_addr  = 4'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read  = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask : rd
   // high byte first so the low write commits the whole word
   task automatic wr16(input logic [3:0] a, input logic [15:0] d);
      wr(a + 4'h1, d[15:8]);
      wr(a, d[7:0]);
   endtask : wr16
   // no handler runs here, so nothing touches the shadow between the reads
   task automatic rd16(input logic [3:0] a, output logic [15:0] d);
      rd(a, d[7:0]);
      rd(a + 4'h1, d[15:8]);
   endtask : rd16
endmodule : tpc_cpu_model
`default_nettype wire

// File: testbench/tb.sv
// tb: runs the timer through the cpu model, checks registers and pwm pins
// assumes package, design, checker and model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        ref_clk           = 1'b0;
   logic        rst               = 1'b1;
   logic        capture_input_pin = 1'b0;
   logic        ext_clk_pin       = 1'b0;
   wire  [3:0]  reg_addr;
   wire  [7:0]  reg_wdata;
   wire         reg_write;
   wire         reg_read;
   wire  [7:0]  reg_rdata;
   wire         compare_a_output;
   wire         compare_a_output_en;
   wire         compare_b_output;
   wire         compare_b_output_en;
   wire         irq;
   int          n_fail     = 0;
   int          n_compared = 0;
   logic [15:0] tops [1:3] = '{tpc_pkg::TOP_8BIT, tpc_pkg::TOP_9BIT, tpc_pkg::TOP_10BIT};
   tpc_timer uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .capture_input_pin, .ext_clk_pin, .compare_a_output, .compare_a_output_en,
      .compare_b_output, .compare_b_output_en, .irq);
   tpc_cpu_model cpu (.ref_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);
   always #5 ref_clk = ~ref_clk;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected result at %0t: %h, want %h", $time, got, exp);
      end
   endtask : check
   function automatic logic pin(input bit ch);
      return ch ? compare_b_output : compare_a_output;
   endfunction : pin
   task automatic stay(input bit ch, input logic lvl, input int lim, output int n);
      n = 0;
      while (pin(ch) === lvl && n < lim)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask : stay
   // skips a partial pulse, then times one whole one
   task automatic measure(input bit ch, output int hi, output int per);
      int lo;
      stay(ch, 1'b1, 20000, lo);
      stay(ch, 1'b0, 20000, lo);
      stay(ch, 1'b1, 20000, hi);
      stay(ch, 1'b0, 20000, lo);
      per = hi + lo;
   endtask : measure
   task automatic drive(input bit ext, input logic lvl);
      @(posedge ref_clk);
      if (ext)
         ext_clk_pin <= lvl;
      else
         capture_input_pin <= lvl;
      repeat (4) @(posedge ref_clk);
   endtask : drive
   task automatic end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   initial
   begin
      #1000000;
      n_fail++;
      end_of_test();
   end
   initial
   begin
      logic [7:0]  b;
      logic [15:0] v;
      int          hi;
      int          per;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++)
      begin
         cpu.rd(4'(a), b);
         check({8'h00, b}, 16'h0000);
      end
      cpu.wr16(tpc_pkg::ADDR_CAP_LOW, 16'hFFFF);
      cpu.rd16(tpc_pkg::ADDR_CAP_LOW, v);
      check(v, 16'h0000);
      // counter stopped, so every captured word is known exactly
      cpu.wr(tpc_pkg::ADDR_CTRL_B, 8'h40);
      cpu.wr16(tpc_pkg::ADDR_CNT_LOW, 16'h1234);
      drive(1'b0, 1'b1);
      cpu.wr16(tpc_pkg::ADDR_CNT_LOW, 16'h5678);
      drive(1'b0, 1'b0);
      cpu.rd16(tpc_pkg::ADDR_CAP_LOW, v);
      check(v, 16'h1234);
      cpu.rd(tpc_pkg::ADDR_FLAGS, b);
      check({15'h0000, b[3]}, 16'h0001);
      cpu.wr(tpc_pkg::ADDR_CTRL_B, 8'h00);
      cpu.wr16(tpc_pkg::ADDR_CNT_LOW, 16'hABCD);
      drive(1'b0, 1'b1);
      cpu.rd(tpc_pkg::ADDR_CAP_LOW, b);
      check({8'h00, b}, 16'h0034);
      drive(1'b0, 1'b0);
      cpu.wr16(tpc_pkg::ADDR_CNT_LOW, 16'h1111);
      cpu.rd(tpc_pkg::ADDR_CAP_LOW, b);
      check({8'h00, b}, 16'h00CD);
      cpu.rd(tpc_pkg::ADDR_CNT_HIGH, b);
      check({8'h00, b}, 16'h00AB);
      for (int c = 6; c < 8; c++)
      begin
         cpu.wr16(tpc_pkg::ADDR_CNT_LOW, 16'h0000);
         cpu.wr(tpc_pkg::ADDR_CTRL_B, 8'(c));
         repeat (3)
         begin
            drive(1'b1, 1'b1);
            drive(1'b1, 1'b0);
         end
         cpu.wr(tpc_pkg::ADDR_CTRL_B, 8'h00);
         cpu.rd16(tpc_pkg::ADDR_CNT_LOW, v);
         check(v, 16'h0003);
      end
      cpu.wr16(tpc_pkg::ADDR_CMPA_LOW, 16'h0040);
      cpu.wr16(tpc_pkg::ADDR_CMPB_LOW, 16'h0040);
      cpu.wr(tpc_pkg::ADDR_CTRL_B, 8'h09);
      for (int r = 1; r < 4; r++)
      begin
         // a non-inverted, b inverted, clear-on-match left set
         cpu.wr(tpc_pkg::ADDR_CTRL_A, 8'hB0 | 8'(r));
         measure(1'b0, hi, per);
         check(16'(hi), 16'h0080);
         check(16'(per), {tops[r][14:0], 1'b0});
         measure(1'b1, hi, per);
         check(16'(per - hi), 16'h0080);
      end
      cpu.wr(tpc_pkg::ADDR_CTRL_A, 8'h53);
      @(negedge ref_clk);
      check({14'h0000, compare_a_output_en, compare_b_output_en}, 16'h0000);
      cpu.wr(tpc_pkg::ADDR_CTRL_A, 8'hB3);
      cpu.wr16(tpc_pkg::ADDR_CMPA_LOW, 16'h0080);
      cpu.rd16(tpc_pkg::ADDR_CMPA_LOW, v);
      check(v, 16'h0080);
      measure(1'b0, hi, per);
      check(16'(hi == 128 || hi == 256), 16'h0001);
      measure(1'b0, hi, per);
      check(16'(hi), 16'h0100);
      cpu.wr16(tpc_pkg::ADDR_CMPA_LOW, 16'h0000);
      cpu.wr16(tpc_pkg::ADDR_CMPB_LOW, 16'h0000);
      repeat (4200) @(negedge ref_clk);
      stay(1'b0, 1'b0, 2100, hi);
      check(16'(hi), 16'h0834);
      stay(1'b1, 1'b1, 2100, hi);
      check(16'(hi), 16'h0834);
      cpu.wr(tpc_pkg::ADDR_CTRL_B, 8'h00);
      cpu.wr16(tpc_pkg::ADDR_CNT_LOW, 16'h0000);
      cpu.wr(tpc_pkg::ADDR_CTRL_A, 8'hB1);
      cpu.wr16(tpc_pkg::ADDR_CMPA_LOW, tpc_pkg::TOP_8BIT);
      cpu.wr(tpc_pkg::ADDR_CTRL_B, 8'h02);
      stay(1'b0, 1'b0, 20000, hi);
      stay(1'b0, 1'b1, 20000, hi);
      check(16'(hi), 16'(16 * int'(tops[1])));
      cpu.wr(tpc_pkg::ADDR_CTRL_B, 8'h01);
      cpu.wr(tpc_pkg::ADDR_IRQ_EN, 8'h07);
      cpu.wr(tpc_pkg::ADDR_FLAGS, 8'h0F);
      repeat (600) @(negedge ref_clk);
      stay(1'b0, compare_a_output, 1100, hi);
      check(16'(hi), 16'h044C);
      check({15'h0000, irq}, 16'h0000);
      cpu.rd(tpc_pkg::ADDR_FLAGS, b);
      check({13'h0000, b[2:0]}, 16'h0007);
      for (int f = 0; f < 3; f++)
      begin
         cpu.wr(tpc_pkg::ADDR_FLAGS, 8'h0F);
         cpu.wr(tpc_pkg::ADDR_IRQ_EN, 8'h80 | (8'h01 << f));
         hi = 0;
         while (irq !== 1'b1 && hi < 600)
         begin
            @(negedge ref_clk);
            hi++;
         end
         check(16'(hi < 600), 16'h0001);
      end
      cpu.wr(tpc_pkg::ADDR_IRQ_EN, 8'h04);
      @(negedge ref_clk);
      check({15'h0000, irq}, 16'h0000);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
